// >>> verilog/rxd_pkg.sv
package rxd_pkg;
	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int CLK_NS    = 40;
	localparam int FRAME_NS  = 125000;
	localparam int FRAME_CYC = FRAME_NS / CLK_NS;

	// ----------------------------------------------------------------
	// packet and report layout
	// ----------------------------------------------------------------
	localparam int HDR_BYTES = 3;
	localparam int OCTET_ADD = 4;
	localparam int RPT_WORDS = 5;
	localparam int RPT_BYTES = RPT_WORDS * 4;
	localparam int ADDR_W    = 24;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_CFG      = 8'h04;
	localparam logic [7:0] OFS_MAX_EXP  = 8'h08;
	localparam logic [7:0] OFS_MAX_USED = 8'h0c;
	localparam logic [7:0] OFS_INIT_LD  = 8'h10;
	localparam logic [7:0] OFS_UND_LD   = 8'h14;
	localparam logic [7:0] OFS_OVR_LD   = 8'h18;
	localparam logic [7:0] OFS_MIN_D    = 8'h1c;
	localparam logic [7:0] OFS_MAX_D    = 8'h20;
	localparam logic [7:0] OFS_LAST_RTS = 8'h24;
	localparam logic [7:0] OFS_PKT_CNT  = 8'h28;
	localparam logic [7:0] OFS_OCT_CNT  = 8'h2c;
	localparam logic [7:0] OFS_LAST_SMP = 8'h30;
	localparam logic [7:0] OFS_Q_BASE   = 8'h34;
	localparam logic [7:0] OFS_Q_WP     = 8'h38;
	localparam logic [7:0] OFS_LOCAL_TS = 8'h3c;
	localparam logic [7:0] OFS_CH_ADDR  = 8'h40;

	// ----------------------------------------------------------------
	// control bits, cfg fields
	// ----------------------------------------------------------------
	localparam int CTRL_RESTART = 0;
	localparam int CTRL_SLIP    = 1;
	localparam int CTRL_ALWAYS  = 2;
	localparam int CTRL_INIT    = 3;
	localparam int CTRL_CINIT   = 4;
	localparam int CTRL_BS_LSB  = 8;
	localparam int CFG_BASE_LSB = 8;

	// ----------------------------------------------------------------
	// report flag positions
	// ----------------------------------------------------------------
	localparam int RF_LATE    = 0;
	localparam int RF_U       = 1;
	localparam int RF_O       = 2;
	localparam int RF_INIT    = 3;
	localparam int RF_CINIT   = 4;
	localparam int RF_RESTART = 5;
	localparam int RF_LOST    = 6;
	localparam int RF_NM      = 7;
	localparam int RF_OVF     = 8;
	localparam int RF_W       = 9;

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  NUM_CH_RST  = 8'h01;
	localparam logic [2:0]  BS_RST      = 3'h0;
	localparam logic [15:0] UND_LD_RST  = 16'h0008;
	localparam logic [10:0] MAX_EXP_RST = 11'h000;

	typedef enum logic [2:0] {
		RXD_IDLE = 3'b000,
		RXD_DIV  = 3'b001,
		RXD_EVAL = 3'b010,
		RXD_SMP  = 3'b011,
		RXD_RPT  = 3'b100
	} rxd_state_t;

	typedef enum logic [2:0] {
		RXD_FE_H0  = 3'b000,
		RXD_FE_H1  = 3'b001,
		RXD_FE_H2  = 3'b010,
		RXD_FE_HDR = 3'b011,
		RXD_FE_PAY = 3'b100
	} rxd_fe_state_t;
endpackage

// >>> verilog/rxd_link_if.sv
`timescale 1ns/10ps
interface rxd_link_if (
	input wire logic pclk,
	input wire logic presetn
);
	import rxd_pkg::*;
	logic              hdr_valid;
	logic              hdr_ready;
	logic [5:0]        hdr_li;
	logic [3:0]        hdr_seq;
	logic              smp_valid;
	logic              smp_ready;
	logic [7:0]        smp_data;
	logic              mem_valid;
	logic              mem_ready;
	logic [ADDR_W-1:0] mem_addr;
	logic [31:0]       mem_data;
	logic              mem_word;

	modport dev (
		input  pclk, presetn, hdr_valid, hdr_li, hdr_seq,
		input  smp_valid, smp_data, mem_ready,
		output hdr_ready, smp_ready, mem_valid, mem_addr, mem_data,
		output mem_word
	);
	modport pde (
		input  pclk, presetn, hdr_ready, smp_ready, mem_valid,
		input  mem_addr, mem_data, mem_word,
		output hdr_valid, hdr_li, hdr_seq, smp_valid, smp_data,
		output mem_ready
	);
endinterface

// >>> verilog/rxd_rpt.sv
`timescale 1ns/10ps
module rxd_rpt import rxd_pkg::*; #(
	parameter int NW = RPT_WORDS
) (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              start,
	input  wire logic [ADDR_W-1:0] base,
	input  wire logic [NW*32-1:0]  words,
	output logic                   mem_valid,
	input  wire logic              mem_ready,
	output logic [ADDR_W-1:0]      mem_addr,
	output logic [31:0]            mem_data,
	output logic                   done
);
	// ----------------------------------------------------------------
	// record writer: words go out lowest first, one per accepted beat
	// ----------------------------------------------------------------
	generate
		if (NW < 1)
			$error("rxd_rpt: NW must be at least 1");
	endgenerate

	logic [7:0] idx;
	wire        beat = mem_valid & mem_ready;
	wire        last = (idx == 8'(NW - 1));
	wire [7:0]  nidx = idx + 8'h01;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_valid <= 1'b0;
			idx       <= 8'h00;
			mem_addr  <= '0;
			mem_data  <= 32'h0000_0000;
			done      <= 1'b0;
		end else begin
			done <= beat & last;
			if (start && !mem_valid) begin
				mem_valid <= 1'b1;
				idx       <= 8'h00;
				mem_addr  <= base;
				mem_data  <= words[31:0];
			end else if (beat) begin
				mem_valid <= ~last;
				idx       <= nidx;
				mem_addr  <= mem_addr + ADDR_W'(4);
				if (!last)
					mem_data <= words[32*nidx +: 32];
			end
		end
	end
endmodule

// >>> verilog/rxd_dev.sv
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/10ps
//
// Operation
// - restart bit opens new period, hardware clears it
// - new period loads min and max delta
// - initialized bit set on first packet
// - store sample count of each packet
// - max expected samples absorbs size changes
// - max used samples bounds buffer depth
// - first packet written at init lead
// - underrun packet written at underrun lead
// - overrun packet written at overrun lead
// - track min and max timestamp delta
// - keep last reconstructed remote timestamp
// - count every packet reaching channel
// - add length indicator plus four octets
// - buffer address from base in 256-byte units
// - flag payload not divisible by bearers
// - flag packet too large for buffer
// - report lost samples with 32-bit count
// - report channel and common structure init
// - report carries address and both timestamps
// - flag late packet underrun
// - flag overrun beyond used depth
// - slip report enable reports slips
module rxd_dev import rxd_pkg::*; #(
	parameter int QDEPTH = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [7:0]  paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic             pready,
	output logic [31:0]      prdata,
	output logic             pslverr,
	rxd_link_if.dev          lnk
);
	localparam int QW = $clog2(QDEPTH);

	generate
		if (QDEPTH < 2 || (QDEPTH & (QDEPTH - 1)) != 0)
			$error("rxd_dev: QDEPTH must be a power of two >= 2");
	endgenerate

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	rxd_state_t      state;
	logic            restart, slip_en, always_rpt, ch_init, cs_init;
	logic [2:0]      bs;
	logic [7:0]      num_ch;
	logic [15:0]     buf_base;
	logic [10:0]     max_exp, max_used, last_smp;
	logic [15:0]     init_ld, und_ld, ovr_ld;
	logic [31:0]     min_d, max_d, last_rts, pkt_cnt, oct_cnt;
	logic [31:0]     local_ts, ts_off, rts, lost;
	logic [ADDR_W-1:0] q_base, ch_addr;
	logic [QW-1:0]   q_wp;
	logic [11:0]     frame_div;
	logic [3:0]      seq, last_seq;
	logic [6:0]      nsamp, rem, frames, last_frames, scnt;
	logic [12:0]     bidx;
	logic [RF_W-1:0] flags;
	logic            discard, rpt_go, rpt_done, rpt_valid;
	logic            rep_pend;
	logic [ADDR_W-1:0] rpt_addr;
	logic [31:0]     rpt_data, rd_word;

	// ----------------------------------------------------------------
	// apb decode
	// ----------------------------------------------------------------
	function automatic logic wr_at(input logic [7:0] ofs);
		return psel & penable & pwrite & (paddr == ofs);
	endfunction

	wire mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_CH_ADDR);
	wire wr_ctrl = wr_at(OFS_CTRL);
	wire wr_cfg  = wr_at(OFS_CFG);
	assign pready  = 1'b1;
	assign pslverr = psel & penable & ~mapped;

	always_comb begin
		unique case (paddr)
		OFS_CTRL:     rd_word = {21'h0, bs, 3'h0, cs_init, ch_init,
		                         always_rpt, slip_en, restart};
		OFS_CFG:      rd_word = {8'h0, buf_base, num_ch};
		OFS_MAX_EXP:  rd_word = {21'h0, max_exp};
		OFS_MAX_USED: rd_word = {21'h0, max_used};
		OFS_INIT_LD:  rd_word = {16'h0, init_ld};
		OFS_UND_LD:   rd_word = {16'h0, und_ld};
		OFS_OVR_LD:   rd_word = {16'h0, ovr_ld};
		OFS_MIN_D:    rd_word = min_d;
		OFS_MAX_D:    rd_word = max_d;
		OFS_LAST_RTS: rd_word = last_rts;
		OFS_PKT_CNT:  rd_word = pkt_cnt;
		OFS_OCT_CNT:  rd_word = oct_cnt;
		OFS_LAST_SMP: rd_word = {21'h0, last_smp};
		OFS_Q_BASE:   rd_word = {8'h0, q_base};
		OFS_Q_WP:     rd_word = 32'(q_wp);
		OFS_LOCAL_TS: rd_word = local_ts;
		OFS_CH_ADDR:  rd_word = {8'h0, ch_addr};
		default:      rd_word = 32'h0000_0000;
		endcase
	end

	// ----------------------------------------------------------------
	// packet evaluation
	// ----------------------------------------------------------------
	wire        hdr_take = lnk.hdr_valid & lnk.hdr_ready;
	wire        first    = ~ch_init;
	wire [3:0]  dseq     = seq - last_seq;
	wire [31:0] step     = 32'(dseq) * 32'(last_frames);
	// remote time rebuilt from the sequence gap and last non-discarded packet's length
	wire [31:0] remote_w = first ? 32'h0 : last_rts + step;
	wire [31:0] lost_w   = (first || dseq < 4'h2) ? 32'h0 :
	                       32'(32'(dseq - 4'h1) * 32'(last_frames)
	                       * 32'(num_ch));
	wire [31:0] delta_w  = local_ts - remote_w;
	wire        new_per  = restart | first;
	wire [31:0] lead_w   = remote_w + ts_off - local_ts;
	// a packet shorter than the worst case needs that much extra lead
	wire [31:0] slack_w  = (max_exp > 11'(frames)) ?
	                       32'(max_exp - 11'(frames)) : 32'h0;
	wire        late_w   = ~first & lead_w[31];
	wire        u_w      = ~first & ($signed(lead_w) < $signed(slack_w));
	wire [31:0] tail_w   = lead_w + 32'(frames) - 32'h1;
	wire        o_w      = ~first & ~u_w &
	                       ($signed(tail_w) > $signed(32'(max_used)));
	wire        nm_w     = (rem != 7'h0) | (num_ch == 8'h0);
	wire        ovf_w    = (11'(frames) > max_used + 11'h1);
	wire        disc_w   = nm_w | ovf_w;
	wire [15:0] lead_sel = first ? init_ld : (u_w ? und_ld : ovr_ld);
	wire        reseat   = first | u_w | o_w;
	wire [31:0] off_w    = reseat ? local_ts + 32'(lead_sel) - remote_w
	                              : ts_off;
	wire [31:0] bstart_w = (remote_w + off_w) * 32'(num_ch);
	wire        gap_w    = (lost_w != 32'h0);
	wire        slip_w   = u_w | late_w | o_w;
	wire        rep_w    = (slip_en & slip_w) | always_rpt | disc_w |
	                       gap_w | first | restart;
	wire [RF_W-1:0] flg_w;
	assign flg_w[RF_LATE]    = late_w;
	assign flg_w[RF_U]       = u_w;
	assign flg_w[RF_O]       = o_w;
	assign flg_w[RF_INIT]    = first;
	assign flg_w[RF_CINIT]   = ~cs_init;
	assign flg_w[RF_RESTART] = restart;
	assign flg_w[RF_LOST]    = gap_w;
	assign flg_w[RF_NM]      = nm_w;
	assign flg_w[RF_OVF]     = ovf_w;

	// ----------------------------------------------------------------
	// circular buffer and queue addressing
	// ----------------------------------------------------------------
	wire [12:0] bmask   = (13'h0100 << bs) - 13'h1;
	wire [ADDR_W-1:0] smp_addr = {buf_base, 8'h00}
	                           + ADDR_W'(bidx & bmask);
	wire [ADDR_W-1:0] q_addr   = q_base
	                           + ADDR_W'(q_wp) * ADDR_W'(RPT_BYTES);
	wire        in_smp  = (state == RXD_SMP);
	wire        smp_beat = lnk.smp_valid & lnk.smp_ready;
	wire        smp_last = (scnt == nsamp - 7'h1);

	assign lnk.hdr_ready = (state == RXD_IDLE);
	assign lnk.smp_ready = in_smp & (discard | lnk.mem_ready);
	assign lnk.mem_valid = (state == RXD_RPT) ? rpt_valid
	                     : in_smp & ~discard & lnk.smp_valid;
	assign lnk.mem_addr  = (state == RXD_RPT) ? rpt_addr : smp_addr;
	assign lnk.mem_data  = (state == RXD_RPT) ? rpt_data
	                     : {24'h0, lnk.smp_data};
	assign lnk.mem_word  = (state == RXD_RPT);

	rxd_rpt #(.NW(RPT_WORDS)) u_rpt (
		.pclk      (pclk),
		.presetn   (presetn),
		.start     (rpt_go),
		.base      (q_addr),
		.words     ({local_ts, rts, lost, 8'h0, ch_addr,
		             23'h0, flags}),
		.mem_valid (rpt_valid),
		.mem_ready (lnk.mem_ready & (state == RXD_RPT)),
		.mem_addr  (rpt_addr),
		.mem_data  (rpt_data),
		.done      (rpt_done)
	);

	// ----------------------------------------------------------------
	// software registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata   <= 32'h0000_0000;
			restart  <= 1'b0;
			slip_en  <= 1'b0;
			always_rpt <= 1'b0;
			ch_init  <= 1'b0;
			cs_init  <= 1'b0;
			bs       <= BS_RST;
			num_ch   <= NUM_CH_RST;
			buf_base <= 16'h0000;
			max_exp  <= MAX_EXP_RST;
			max_used <= 11'h000;
			init_ld  <= 16'h0000;
			und_ld   <= UND_LD_RST;
			ovr_ld   <= 16'h0000;
			last_smp <= 11'h000;
			q_base   <= '0;
			ch_addr  <= '0;
		end else begin
			if (psel && !penable)
				prdata <= mapped ? rd_word : 32'h0000_0000;
			if (wr_ctrl) begin
				restart    <= pwdata[CTRL_RESTART];
				slip_en    <= pwdata[CTRL_SLIP];
				always_rpt <= pwdata[CTRL_ALWAYS];
				bs         <= pwdata[CTRL_BS_LSB +: 3];
			end else if (state == RXD_EVAL)
				restart <= 1'b0;
			// hardware set beats a software clear in the same cycle
			if (state == RXD_EVAL) begin
				ch_init <= 1'b1;
				cs_init <= 1'b1;
			end else if (wr_ctrl) begin
				ch_init <= pwdata[CTRL_INIT];
				cs_init <= pwdata[CTRL_CINIT];
			end
			if (wr_cfg) begin
				num_ch   <= pwdata[7:0];
				buf_base <= pwdata[CFG_BASE_LSB +: 16];
			end
			if (wr_at(OFS_MAX_EXP))  max_exp  <= pwdata[10:0];
			if (wr_at(OFS_MAX_USED)) max_used <= pwdata[10:0];
			if (wr_at(OFS_INIT_LD))  init_ld  <= pwdata[15:0];
			if (wr_at(OFS_UND_LD))   und_ld   <= pwdata[15:0];
			if (wr_at(OFS_OVR_LD))   ovr_ld   <= pwdata[15:0];
			if (wr_at(OFS_Q_BASE))   q_base   <= pwdata[ADDR_W-1:0];
			if (wr_at(OFS_CH_ADDR))  ch_addr  <= pwdata[ADDR_W-1:0];
			if (state == RXD_EVAL)
				last_smp <= 11'(nsamp);
			else if (wr_at(OFS_LAST_SMP))
				last_smp <= pwdata[10:0];
		end
	end

	// ----------------------------------------------------------------
	// local frame clock
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame_div <= 12'h000;
			local_ts  <= 32'h0000_0000;
		end else if (frame_div == 12'(FRAME_CYC - 1)) begin
			frame_div <= 12'h000;
			local_ts  <= local_ts + 32'h1;
		end else
			frame_div <= frame_div + 12'h001;
	end

	// ----------------------------------------------------------------
	// packet sequencer
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state   <= RXD_IDLE;
			seq     <= 4'h0;
			last_seq <= 4'h0;
			nsamp   <= 7'h0;
			rem     <= 7'h0;
			frames  <= 7'h0;
			last_frames <= 7'h0;
			scnt    <= 7'h0;
			bidx    <= 13'h0;
			pkt_cnt <= 32'h0;
			oct_cnt <= 32'h0;
			min_d   <= 32'h0;
			max_d   <= 32'h0;
			last_rts <= 32'h0;
			ts_off  <= 32'h0;
			rts     <= 32'h0;
			lost    <= 32'h0;
			flags   <= '0;
			discard <= 1'b0;
			rpt_go  <= 1'b0;
			q_wp    <= '0;
		end else begin
			rpt_go <= 1'b0;
			unique case (state)
			RXD_IDLE: if (hdr_take) begin
				seq     <= lnk.hdr_seq;
				nsamp   <= 7'(lnk.hdr_li) + 7'h1;
				rem     <= 7'(lnk.hdr_li) + 7'h1;
				frames  <= 7'h0;
				pkt_cnt <= pkt_cnt + 32'h1;
				oct_cnt <= oct_cnt + 32'(lnk.hdr_li)
				         + 32'(OCTET_ADD);
				state   <= RXD_DIV;
			end
			// frames per bearer by repeated subtraction
			RXD_DIV: if (num_ch != 8'h0 && 8'(rem) >= num_ch) begin
				rem    <= rem - 7'(num_ch);
				frames <= frames + 7'h1;
			end else
				state <= RXD_EVAL;
			RXD_EVAL: begin
				rts      <= remote_w;
				last_rts <= remote_w;
				last_seq <= seq;
				lost     <= lost_w;
				flags    <= flg_w;
				discard  <= disc_w;
				scnt     <= 7'h0;
				bidx     <= 13'(bstart_w);
				if (new_per || $signed(delta_w) < $signed(min_d))
					min_d <= delta_w;
				if (new_per || $signed(delta_w) > $signed(max_d))
					max_d <= delta_w;
				if (!disc_w) begin
					last_frames <= frames;
					ts_off      <= off_w;
				end
				state <= RXD_SMP;
			end
			RXD_SMP: if (smp_beat) begin
				scnt <= scnt + 7'h1;
				bidx <= bidx + 13'h1;
				if (smp_last) begin
					state  <= rep_pend ? RXD_RPT : RXD_IDLE;
					rpt_go <= rep_pend;
				end
			end
			RXD_RPT: if (rpt_done) begin
				q_wp  <= q_wp + QW'(1);
				state <= RXD_IDLE;
			end
			default: state <= RXD_IDLE;
			endcase
		end
	end

	// report decision held from evaluation to end of payload
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rep_pend <= 1'b0;
		else if (state == RXD_EVAL)
			rep_pend <= rep_w;
	end
endmodule

// >>> verilog/rxd_pde.sv
`timescale 1ns/10ps
module rxd_pde import rxd_pkg::*; (
	input  wire logic        pclk,
	input  wire logic        presetn,
	rxd_link_if.pde          lnk,
	input  wire logic        in_valid,
	output logic             in_ready,
	input  wire logic [7:0]  in_data,
	output logic             out_valid,
	input  wire logic        out_ready,
	output logic [ADDR_W-1:0] out_addr,
	output logic [31:0]      out_data,
	output logic             out_word
);
	// ----------------------------------------------------------------
	// cps packet splitter: three header bytes, then li+1 payload bytes
	// ----------------------------------------------------------------
	rxd_fe_state_t st;
	logic [5:0]    li, cnt;
	logic [1:0]    uui_hi;
	logic [3:0]    seq;

	wire in_hdr  = (st == RXD_FE_H0) | (st == RXD_FE_H1) |
	               (st == RXD_FE_H2);
	wire in_pay  = (st == RXD_FE_PAY);
	wire take    = in_valid & in_ready;

	assign in_ready      = in_hdr | (in_pay & lnk.smp_ready);
	assign lnk.hdr_valid = (st == RXD_FE_HDR);
	assign lnk.hdr_li    = li;
	assign lnk.hdr_seq   = seq;
	assign lnk.smp_valid = in_pay & in_valid;
	assign lnk.smp_data  = in_data;
	// a full output stage that out_ready does not drain stalls memory writes from the device
	assign lnk.mem_ready = ~out_valid | out_ready;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st     <= RXD_FE_H0;
			li     <= 6'h00;
			cnt    <= 6'h00;
			uui_hi <= 2'h0;
			seq    <= 4'h0;
		end else begin
			unique case (st)
			RXD_FE_H0: if (take)
				st <= RXD_FE_H1;
			RXD_FE_H1: if (take) begin
				li     <= in_data[7:2];
				uui_hi <= in_data[1:0];
				st     <= RXD_FE_H2;
			end
			RXD_FE_H2: if (take) begin
				seq <= {uui_hi[0], in_data[7:5]};
				st  <= RXD_FE_HDR;
			end
			RXD_FE_HDR: if (lnk.hdr_ready) begin
				cnt <= 6'h00;
				st  <= RXD_FE_PAY;
			end
			RXD_FE_PAY: if (take) begin
				cnt <= cnt + 6'h01;
				if (cnt == li)
					st <= RXD_FE_H0;
			end
			default: st <= RXD_FE_H0;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// registered memory write stage
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_valid <= 1'b0;
			out_addr  <= '0;
			out_data  <= 32'h0000_0000;
			out_word  <= 1'b0;
		end else if (lnk.mem_valid && lnk.mem_ready) begin
			out_valid <= 1'b1;
			out_addr  <= lnk.mem_addr;
			out_data  <= lnk.mem_data;
			out_word  <= lnk.mem_word;
		end else if (out_ready)
			out_valid <= 1'b0;
	end
endmodule

// >>> verif/rxd_chk.sv
`timescale 1ns/10ps
module rxd_chk import rxd_pkg::*; (
	input wire logic		pclk,
	input wire logic		presetn,
	input wire logic		hdr_valid,
	input wire logic		hdr_ready,
	input wire logic [5:0]		hdr_li,
	input wire logic [3:0]		hdr_seq,
	input wire logic		smp_valid,
	input wire logic		smp_ready,
	input wire logic		mem_valid,
	input wire logic		mem_ready,
	input wire logic [ADDR_W-1:0]	mem_addr,
	input wire logic [31:0]		mem_data,
	input wire logic		mem_word
);
	// ----
	// sample beats still owed by the packet in flight
	// ----
	logic [6:0]	rem;
	wire		take = hdr_valid && hdr_ready;
	wire		beat = smp_valid && smp_ready;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			rem <= 7'h00;
		else if (take)
			rem <= {1'b0, hdr_li} + 7'h01;
		else if (beat)
			rem <= rem - 7'h01;
	end
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence take_s;
		hdr_valid && hdr_ready;
	endsequence
	hdr_hold_a: assert property (hdr_valid && !hdr_ready |=>
		hdr_valid && $stable({hdr_li, hdr_seq})) else $error("header moved");
	mem_hold_a: assert property (mem_valid && !mem_ready |=>
		mem_valid && $stable({mem_addr, mem_data, mem_word}))
		else $error("memory beat moved");
	busy_hdr_a: assert property (beat |-> !hdr_ready)
		else $error("header open mid packet");
	smp_count_a: assert property (beat |-> rem != 7'h00)
		else $error("sample beyond length");
	pkt_whole_a: assert property (take_s |-> rem == 7'h00)
		else $error("header before packet end");
	byte_path_a: assert property (mem_valid && !mem_word |-> smp_valid)
		else $error("buffer write without sample");
	word_align_a: assert property (mem_valid && mem_word |->
		mem_addr[1:0] == 2'b00) else $error("report word unaligned");
	take_busy_a: assert property (take_s |=> !hdr_ready && !smp_ready)
		else $error("idle after header");
endmodule

// >>> verif/tb_rx_aal2_pdv_absorption.sv
`timescale 1ns/10ps
module tb_rx_aal2_pdv_absorption import rxd_pkg::*; ;
	logic		pclk = 1'b0, presetn = 1'b0, err, pready, pslverr;
	logic		psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic		in_valid = 1'b0, out_ready = 1'b0;
	logic		in_ready, out_valid, out_word;
	logic [7:0]	paddr = 8'h00, in_data = 8'h00, pa;
	logic [31:0]	pwdata = 32'h0, prdata, out_data, rd, wq[$];
	logic [ADDR_W-1:0]	out_addr, wa[$];
	int		n_errors = 0, n_compared = 0, cyc = 0, nb = 0, qn = 0;
	// ----
	// rows: seq, length; remote stamp, lost, octets, report flags
	// ----
	logic [3:0]	r_sq[4] = '{4'h0, 4'h1, 4'h3, 4'h4};
	logic [5:0]	r_li[4] = '{6'h03, 6'h03, 6'h07, 6'h01};
	logic [31:0]	r_rts[4] = '{32'h0, 32'h4, 32'hc, 32'h14};
	logic [31:0]	r_lost[4] = '{32'h0, 32'h0, 32'h4, 32'h0};
	logic [31:0]	r_oct[4] = '{32'h7, 32'he, 32'h19, 32'h1e};
	logic [31:0]	r_fl[4] = '{32'h8, 32'h0, 32'h40, 32'h0};
	rxd_link_if lnk (.pclk, .presetn);
	rxd_dev rxd_dev_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
		.pwdata, .pready, .prdata, .pslverr, .lnk(lnk));
	rxd_pde rxd_pde_i (.pclk, .presetn, .lnk(lnk), .in_valid, .in_ready,
		.in_data, .out_valid, .out_ready, .out_addr, .out_data, .out_word);
	rxd_chk rxd_chk_i (.pclk, .presetn, .hdr_valid(lnk.hdr_valid),
		.hdr_ready(lnk.hdr_ready), .hdr_li(lnk.hdr_li),
		.hdr_seq(lnk.hdr_seq), .smp_valid(lnk.smp_valid),
		.smp_ready(lnk.smp_ready), .mem_valid(lnk.mem_valid),
		.mem_ready(lnk.mem_ready), .mem_addr(lnk.mem_addr),
		.mem_data(lnk.mem_data), .mem_word(lnk.mem_word));
	always #20 pclk = ~pclk;
	task automatic chk(input string w, input logic [31:0] e, g);
		n_compared++;
		if (g !== e) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", w, e, g);
		end
	endtask
	task automatic end_sim();
		$display("compared %0d errors %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	// a stalling far side keeps report beats backed up in the out stage
	always @(posedge pclk) begin
		out_ready <= (cyc % 3) != 0;
		if (out_valid && out_ready && out_word) begin
			wq.push_back(out_data);
			wa.push_back(out_addr);
		end
		if (out_valid && out_ready && !out_word) begin
			chk("base", 32'h12, 32'(out_addr[23:8]));
			if (nb > 0)
				chk("step", 32'(8'(pa + 8'h01)), 32'(out_addr[7:0]));
			pa = out_addr[7:0];
			nb++;
		end
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			end_sim();
		end
	end
	task automatic apb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rchk(input string w, input logic [7:0] a,
		input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(w, e, rd);
	endtask
	task automatic sb(input logic [7:0] b);
		in_valid <= 1'b1;
		in_data <= b;
		@(posedge pclk);
		while (in_ready !== 1'b1)
			@(posedge pclk);
	endtask
	task automatic pkt(input logic [3:0] sq, input logic [5:0] li);
		nb = 0;
		wq.delete();
		wa.delete();
		@(posedge pclk);
		sb(8'h10);
		sb({li, 1'b0, sq[3]});
		sb({sq[2:0], 5'h00});
		for (int k = 0; k <= li; k++)
			sb(8'h40 + 8'(k));
		in_valid <= 1'b0;
		repeat (4) @(negedge pclk);
		while (lnk.hdr_ready !== 1'b1 || out_valid !== 1'b0)
			@(negedge pclk);
	endtask
	task automatic rpt(input logic [31:0] fl);
		chk("words", 32'h5, wq.size());
		chk("flags", fl, wq[0] & fl);
		chk("chan", 32'habc00, wq[1]);
		chk("qaddr", 32'h1000 + qn * 20, 32'(wa[0]));
		qn++;
	endtask
	initial begin
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk("ctrl", OFS_CTRL, 32'h0);
		rchk("cfg", OFS_CFG, 32'h1);
		rchk("und", OFS_UND_LD, 32'h8);
		rchk("used", OFS_MAX_USED, 32'h0);
		rchk("void", 8'h80, 32'h0);
		chk("slverr", 32'h1, 32'(err));
		apb(1'b1, OFS_CFG, 32'h1201);
		apb(1'b1, OFS_MAX_USED, 32'hff);
		apb(1'b1, OFS_INIT_LD, 32'h4);
		apb(1'b1, OFS_CH_ADDR, 32'habc00);
		apb(1'b1, OFS_Q_BASE, 32'h1000);
		foreach (r_sq[i]) begin
			pkt(r_sq[i], r_li[i]);
			chk("bytes", 32'(r_li[i]) + 1, nb);
			rchk("pkts", OFS_PKT_CNT, i + 1);
			rchk("octs", OFS_OCT_CNT, r_oct[i]);
			rchk("smps", OFS_LAST_SMP, 32'(r_li[i]) + 1);
			rchk("rts", OFS_LAST_RTS, r_rts[i]);
			if (r_fl[i] != 0) begin
				rpt(r_fl[i]);
				chk("lost", r_lost[i], wq[2]);
				chk("rrts", r_rts[i], wq[3]);
			end else begin
				chk("quiet", 32'h0, wq.size());
			end
		end
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("init", 32'h8, rd & 32'h8);
		apb(1'b1, OFS_CTRL, 32'h19);
		pkt(4'h5, 6'h03);
		rpt(32'h20);
		apb(1'b0, OFS_CTRL, 32'h0);
		chk("restart", 32'h0, rd & 32'h1);
		apb(1'b0, OFS_MIN_D, 32'h0);
		rchk("minmax", OFS_MAX_D, rd);
		apb(1'b1, OFS_CFG, 32'h1202);
		pkt(4'h6, 6'h02);
		chk("nm bytes", 32'h0, nb);
		rpt(32'h80);
		apb(1'b1, OFS_CFG, 32'h1201);
		apb(1'b1, OFS_MAX_USED, 32'h3);
		pkt(4'h7, 6'h07);
		rpt(32'h100);
		apb(1'b1, OFS_OVR_LD, 32'h2);
		apb(1'b1, OFS_CTRL, 32'h1a);
		pkt(4'h8, 6'h01);
		rpt(32'h4);
		chk("olead", 32'h3, 32'(pa));
		chk("orts", 32'h22, wq[3]);
		apb(1'b1, OFS_OCT_CNT, 32'h55);
		rchk("pkts", OFS_PKT_CNT, 32'h8);
		rchk("octs", OFS_OCT_CNT, 32'h3b);
		presetn <= 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		rchk("rst pkts", OFS_PKT_CNT, 32'h0);
		rchk("rst ctrl", OFS_CTRL, 32'h0);
		rchk("rst und", OFS_UND_LD, 32'h8);
		end_sim();
	end
endmodule
